/* hw/wofs_defines.vh */
// Constants for the weld output function selector.
`ifndef WOFS_DEFINES_VH
`define WOFS_DEFINES_VH
// ==========================================================
// Function codes
`define WOFS_FN_THERMAL 5'h0B
`define WOFS_FN_FLASH 5'h0C
`define WOFS_FN_FLASH_VALVE 5'h0D
`define WOFS_FN_FLASH_BREAK 5'h0E
`define WOFS_FN_HW_FAULT 5'h0F
`define WOFS_FN_PHASE_FAULT 5'h10
`define WOFS_FN_GEN_FAULT 5'h11
`define WOFS_FN_FULL_COND 5'h12
`define WOFS_FN_WELD_ONLY 5'h13
`define WOFS_FN_INTERLOCK 5'h14
`define WOFS_FN_SEND_ALL 5'h16
`define WOFS_FN_SEND_OUT 5'h17
`define WOFS_FN_SHOW_OUT 5'h18
`define WOFS_FN_SHOW_ALL 5'h19
`define WOFS_FN_HOLD_PART 5'h1A
`define WOFS_FN_BREAK_VALVE 5'h1B
`define WOFS_FN_EOS_VALVE 5'h1C
// ==========================================================
// Error number reported for a phase fault
`define WOFS_ERR_PHASE 8'h1A
// ==========================================================
// Timing
`define WOFS_CLK_HZ 125000000
`define WOFS_TICK_HZ 1000
`define WOFS_TICK_DIV (`WOFS_CLK_HZ / `WOFS_TICK_HZ)
`define WOFS_VALVE_MS 500
`define WOFS_VALVE_TICKS (`WOFS_VALVE_MS * `WOFS_TICK_HZ / 1000)
`define WOFS_FLASH_TICKS 250
// The same counts at the widths of the counters that use them: the divider wraps at
// TICK_DIV - 1, the flash phase ends at FLASH_TICKS - 1, and the valve loads VALVE_TICKS.
`define WOFS_TICK_LAST 17'h1E847
`define WOFS_FLASH_LAST 8'hF9
`define WOFS_VALVE_LOAD 10'h1F4
`endif

/* hw/wofs_top.v */
// Programmable output function decoder for a weld sequence control.
// Operation
// - Code 15: output on hardware or relay fault.
// - Code 16: output on shorted thyristor/phase loss.
// - Code 17: output on general faults.
// - Code 18: output on full conduction.
// - Code 19: output in weld, mode, inhibit closed.
// - Code 20: output after squeeze through weld.
// - Code 13: flash indicator, valve pulse when out.
// - Code 14: flash indicator, abort sequence when out.
// - Code 22: send after out weld or last.
// - Code 23: send result only when out.
// - Code 24: flash, indicate, show current when out.
// - Code 25: indicate result, end, show current.
// - Code 26: flash, stop in hold when out.
// - Code 27: flash, abort, valve pulse when out.
// - Code 28: valve pulse on good weld end.
// - Code 11: output while thermal switch open.
// - Code 12: flash indicator when out.
`timescale 1ns/1ps
`default_nettype none
`include "wofs_defines.vh"
module wofs_top (
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire [4:0] FUNC_CODE_I,
    input wire SQUEEZE_I,
    input wire WELD_I,
    input wire HOLD_I,
    input wire WELD_MODE_I,
    input wire WELD_INHIBIT_INPUT_I,
    input wire HW_FAULT_I,
    input wire RELAY_FAULT_I,
    input wire THYRISTOR_SHORT_I,
    input wire SECOND_LINE_PHASE_MISSING_I,
    input wire THERMAL_LIMIT_SWITCH_OPEN_I,
    input wire MEMORY_FAULT_I,
    input wire LINE_VOLTAGE_COMPENSATION_FAULT_I,
    input wire STEPPER_END_I,
    input wire FULL_CONDUCTION_I,
    input wire RESULT_VALID_I,
    input wire CURRENT_WINDOW_RESULT_I,
    input wire LAST_WELD_I,
    input wire SERIAL_FITTED_I,
    output reg PROG_OUT_O,
    output reg INDICATOR_O,
    output reg VALVE3_O,
    output reg ABORT_O,
    output reg HOLD_STOP_O,
    output reg SEND_O,
    output reg SHOW_CURRENT_O,
    output reg SEQUENCE_COMPLETE_O,
    output reg [7:0] ERROR_CODE_O
);
    // ==========================================================
    // Input synchronisers
    localparam NS = 18;
    wire [NS-1:0] raw = {SQUEEZE_I, WELD_I, HOLD_I, WELD_MODE_I, WELD_INHIBIT_INPUT_I, HW_FAULT_I,
                         RELAY_FAULT_I, THYRISTOR_SHORT_I, SECOND_LINE_PHASE_MISSING_I,
                         THERMAL_LIMIT_SWITCH_OPEN_I, MEMORY_FAULT_I, LINE_VOLTAGE_COMPENSATION_FAULT_I,
                         STEPPER_END_I, FULL_CONDUCTION_I, RESULT_VALID_I, CURRENT_WINDOW_RESULT_I,
                         LAST_WELD_I, SERIAL_FITTED_I};
    reg [NS-1:0] meta;
    reg [NS-1:0] s;
    reg [4:0] code_meta;
    reg [4:0] code;
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            meta <= {NS{1'b0}};
            s <= {NS{1'b0}};
            code_meta <= 5'h00;
            code <= 5'h00;
        end else begin
            meta <= raw;
            s <= meta;
            code_meta <= FUNC_CODE_I;
            code <= code_meta;
        end
    end
    wire squeeze = s[17];
    wire weld = s[16];
    wire hold = s[15];
    wire weld_mode = s[14];
    // The inhibit input reads high when closed to ground.
    wire inhibit_closed = s[13];
    wire hw_fault = s[12];
    wire relay_fault = s[11];
    wire thy_short = s[10];
    wire phase_missing = s[9];
    wire thermal_open = s[8];
    wire mem_fault = s[7];
    wire comp_fault = s[6];
    wire stepper_end = s[5];
    wire full_cond = s[4];
    wire result_valid = s[3];
    // High means current lies outside the limit window.
    wire out_of_window = s[2];
    wire last_weld = s[1];
    wire serial_fitted = s[0];

    // ==========================================================
    // Timebase tick and derived flash
    reg [16:0] div;
    reg tick;
    reg [7:0] flash_cnt;
    reg flash;
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            div <= 17'h00000;
            tick <= 1'b0;
            flash_cnt <= 8'h00;
            // Flash starts lit so an out-of-window result shows at once, not a quarter second later.
            flash <= 1'b1;
        end else begin
            tick <= (div == `WOFS_TICK_LAST);
            div <= (div == `WOFS_TICK_LAST) ? 17'h00000 : div + 17'h00001;
            if (tick) begin
                if (flash_cnt == `WOFS_FLASH_LAST) begin
                    flash_cnt <= 8'h00;
                    flash <= ~flash;
                end else begin
                    flash_cnt <= flash_cnt + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // Decode
    // Results arrive as a level held for several cycles after each weld; edge-detect it so every
    // measured weld counts as exactly one event.
    reg valid_d;
    wire result_evt = result_valid & ~valid_d;
    wire bad_evt = result_evt & out_of_window;
    wire good_evt = result_evt & ~out_of_window;
    reg [4:0] sel;
    reg next_out;
    reg next_flash_req;
    reg next_abort;
    reg next_hold;
    reg next_send;
    reg next_show;
    reg next_eos;
    reg valve_start;
    reg latched_bad;
    reg squeeze_done;
    reg weld_d;
    always @* begin
        sel = code;
        next_out = 1'b0;
        next_flash_req = 1'b0;
        next_abort = 1'b0;
        next_hold = 1'b0;
        next_send = 1'b0;
        next_show = 1'b0;
        next_eos = 1'b0;
        valve_start = 1'b0;
        case (sel)
            `WOFS_FN_THERMAL: next_out = thermal_open;
            `WOFS_FN_FLASH: next_flash_req = latched_bad;
            `WOFS_FN_FLASH_VALVE: begin
                next_flash_req = latched_bad;
                valve_start = bad_evt;
            end
            `WOFS_FN_FLASH_BREAK: begin
                next_flash_req = latched_bad;
                next_abort = bad_evt;
            end
            `WOFS_FN_HW_FAULT: next_out = hw_fault | relay_fault;
            `WOFS_FN_PHASE_FAULT: next_out = thy_short | phase_missing;
            `WOFS_FN_GEN_FAULT: next_out = thermal_open | mem_fault | comp_fault | stepper_end;
            `WOFS_FN_FULL_COND: next_out = full_cond;
            `WOFS_FN_WELD_ONLY: next_out = weld & weld_mode & inhibit_closed;
            `WOFS_FN_INTERLOCK: next_out = (squeeze_done & ~squeeze & ~weld_d) | weld;
            `WOFS_FN_SEND_ALL: next_send = serial_fitted & (bad_evt | (result_evt & last_weld));
            `WOFS_FN_SEND_OUT: next_send = serial_fitted & bad_evt;
            `WOFS_FN_SHOW_OUT: begin
                next_flash_req = latched_bad;
                next_show = latched_bad;
            end
            `WOFS_FN_SHOW_ALL: begin
                next_show = 1'b1;
                next_eos = result_evt & last_weld;
            end
            `WOFS_FN_HOLD_PART: begin
                next_flash_req = latched_bad;
                next_hold = latched_bad & hold;
            end
            `WOFS_FN_BREAK_VALVE: begin
                next_flash_req = latched_bad;
                next_abort = bad_evt;
                valve_start = bad_evt;
            end
            `WOFS_FN_EOS_VALVE: begin
                valve_start = good_evt & weld_mode & inhibit_closed;
                next_eos = valve_start;
            end
            default: next_out = 1'b0;
        endcase
    end

    // ==========================================================
    // Sequence tracking, valve timer and registered outputs
    reg [9:0] valve_cnt;
    reg [4:0] code_d;
    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            valid_d <= 1'b0;
            weld_d <= 1'b0;
            squeeze_done <= 1'b0;
            latched_bad <= 1'b0;
            valve_cnt <= 10'h000;
            code_d <= 5'h00;
            PROG_OUT_O <= 1'b0;
            INDICATOR_O <= 1'b0;
            VALVE3_O <= 1'b0;
            ABORT_O <= 1'b0;
            HOLD_STOP_O <= 1'b0;
            SEND_O <= 1'b0;
            SHOW_CURRENT_O <= 1'b0;
            SEQUENCE_COMPLETE_O <= 1'b0;
            ERROR_CODE_O <= 8'h00;
        end else begin
            valid_d <= result_valid;
            weld_d <= weld;
            code_d <= code;
            // Set through squeeze and cleared as weld falls, or by hold when a sequence
            // skips its weld, so the interlock never outlives the weld interval.
            if (squeeze) begin
                squeeze_done <= 1'b1;
            end else if (~weld & (weld_d | hold)) begin
                squeeze_done <= 1'b0;
            end
            // The last result is held until the next measurement replaces it.
            if (result_evt) begin
                latched_bad <= out_of_window;
            end
            // A code change ends any running pulse so only one function acts.
            if (code != code_d) begin
                valve_cnt <= 10'h000;
            end else if (valve_start && valve_cnt == 10'h000) begin
                valve_cnt <= `WOFS_VALVE_LOAD;
            end else if (tick && valve_cnt != 10'h000) begin
                valve_cnt <= valve_cnt - 10'h001;
            end
            VALVE3_O <= (valve_cnt != 10'h000);
            PROG_OUT_O <= next_out;
            INDICATOR_O <= next_flash_req & (flash | sel == `WOFS_FN_SHOW_ALL) |
                           (sel == `WOFS_FN_SHOW_ALL & latched_bad);
            ABORT_O <= next_abort;
            HOLD_STOP_O <= next_hold;
            SEND_O <= next_send;
            SHOW_CURRENT_O <= next_show;
            SEQUENCE_COMPLETE_O <= next_eos;
            ERROR_CODE_O <= (thy_short | phase_missing) ? `WOFS_ERR_PHASE : 8'h00;
        end
    end
endmodule
`default_nettype wire

/* bench/wofs_checker.sv */
// Assertion checker for the weld output function selector.
`timescale 1ns/1ps
`default_nettype none
module wofs_checker (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [4:0] FUNC_CODE_I,
    input wire logic WELD_I,
    input wire logic WELD_MODE_I,
    input wire logic WELD_INHIBIT_INPUT_I,
    input wire logic THYRISTOR_SHORT_I,
    input wire logic SECOND_LINE_PHASE_MISSING_I,
    input wire logic RESULT_VALID_I,
    input wire logic CURRENT_WINDOW_RESULT_I,
    input wire logic SERIAL_FITTED_I,
    input wire logic PROG_OUT_O,
    input wire logic VALVE3_O,
    input wire logic ABORT_O,
    input wire logic SEND_O
);
    // ====================================================
    // Properties
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // A result event is the first high sample of a new measurement.
    sequence ev(c, b);
        RESULT_VALID_I && !$past(RESULT_VALID_I) && FUNC_CODE_I == c && CURRENT_WINDOW_RESULT_I == b;
    endsequence
    chk_phase_out: assert property ($past(FUNC_CODE_I, 3) == 5'h10
        |-> PROG_OUT_O == $past(THYRISTOR_SHORT_I | SECOND_LINE_PHASE_MISSING_I, 3)) else $error("phase output");
    chk_weld_only: assert property ($past(FUNC_CODE_I, 3) == 5'h13
        |-> PROG_OUT_O == $past(WELD_I & WELD_MODE_I & WELD_INHIBIT_INPUT_I, 3)) else $error("weld output");
    chk_reserved_quiet: assert property ($past(FUNC_CODE_I, 5) == $past(FUNC_CODE_I, 3)
        && $past(FUNC_CODE_I, 3) inside {5'h15, 5'h1D} |-> !(PROG_OUT_O | VALVE3_O | ABORT_O | SEND_O))
        else $error("reserved code active");
    chk_abort_once: assert property (ev(5'h0E, 1'b1) |-> ##[3:5] ABORT_O ##1 !ABORT_O)
        else $error("abort pulse");
    chk_valve_start: assert property (ev(5'h0D, 1'b1) |-> ##[3:6] VALVE3_O)
        else $error("valve start");
    chk_send_bad: assert property (ev(5'h17, 1'b1) ##0 SERIAL_FITTED_I |-> ##[3:5] SEND_O ##1 !SEND_O)
        else $error("send missing");
    chk_send_quiet: assert property (ev(5'h17, 1'b0) |-> ##1 !SEND_O [*6])
        else $error("send on good");
    chk_eos_valve: assert property (ev(5'h1C, 1'b0) ##0 (WELD_MODE_I && WELD_INHIBIT_INPUT_I)
        |-> ##[3:6] VALVE3_O) else $error("end valve");
    cov_abort: cover property (ev(5'h0E, 1'b1));
    cov_eos: cover property (ev(5'h1C, 1'b0));
    cov_phase: cover property (PROG_OUT_O && FUNC_CODE_I == 5'h10);
endmodule
bind wofs_top wofs_checker wofs_checker_i (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .FUNC_CODE_I(FUNC_CODE_I),
    .WELD_I(WELD_I), .WELD_MODE_I(WELD_MODE_I), .WELD_INHIBIT_INPUT_I(WELD_INHIBIT_INPUT_I),
    .THYRISTOR_SHORT_I(THYRISTOR_SHORT_I), .SECOND_LINE_PHASE_MISSING_I(SECOND_LINE_PHASE_MISSING_I),
    .RESULT_VALID_I(RESULT_VALID_I), .CURRENT_WINDOW_RESULT_I(CURRENT_WINDOW_RESULT_I),
    .SERIAL_FITTED_I(SERIAL_FITTED_I), .PROG_OUT_O(PROG_OUT_O), .VALVE3_O(VALVE3_O), .ABORT_O(ABORT_O),
    .SEND_O(SEND_O));
`default_nettype wire

/* bench/wofs_seq_model.sv */
// Behavioural weld sequence feeding intervals and current results.
`timescale 1ns/1ps
`default_nettype none
module wofs_seq_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic bad_i,
    input wire logic abort_i,
    output logic squeeze_o,
    output logic weld_o,
    output logic hold_o,
    output logic valid_o,
    output logic window_o
);
    // ====================================================
    // Sequence
    // Squeeze 4, weld 4, hold 8 cycles; the result stands 3 cycles early in hold.
    logic [4:0] t = 5'h00;
    always @(posedge clk_i)
        t <= start_i ? 5'h01 : (t == 5'h11 || abort_i || t == 5'h00) ? 5'h00 : t + 5'h01;
    assign squeeze_o = t >= 5'h01 && t <= 5'h04;
    assign weld_o = t >= 5'h05 && t <= 5'h08;
    assign hold_o = t >= 5'h09 && t <= 5'h10;
    assign valid_o = t >= 5'h0A && t <= 5'h0C;
    // Outside a result the line follows t[0], toggling during a run and low when idle, so a stale value never passes for one.
    assign window_o = valid_o ? bad_i : t[0];
endmodule
`default_nettype wire

/* bench/test_weld_output_function_select.sv */
// Self-checking bench for the weld output function selector.
`timescale 1ns/1ps
`default_nettype none
module test_weld_output_function_select;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, bad = 1'b0;
    logic mode = 1'b1, inh = 1'b1, ser = 1'b1, last = 1'b1;
    logic [4:0] code = 5'h00;
    logic [8:0] f = 9'h000;
    logic sq, wd, hd, rv, win, po, ab, v3, hs, snd, ind, shw, sequence_complete;
    logic [7:0] err;
    int n_mismatch = 0, num_checks = 0;
    wofs_top wofs_top_i (.SYS_CLK_I(clk), .SYS_RST_I(rst), .FUNC_CODE_I(code), .SQUEEZE_I(sq), .WELD_I(wd),
        .HOLD_I(hd), .WELD_MODE_I(mode), .WELD_INHIBIT_INPUT_I(inh), .HW_FAULT_I(f[8]), .RELAY_FAULT_I(f[7]),
        .THYRISTOR_SHORT_I(f[6]), .SECOND_LINE_PHASE_MISSING_I(f[5]), .THERMAL_LIMIT_SWITCH_OPEN_I(f[4]),
        .MEMORY_FAULT_I(f[3]), .LINE_VOLTAGE_COMPENSATION_FAULT_I(f[2]), .STEPPER_END_I(f[1]),
        .FULL_CONDUCTION_I(f[0]), .RESULT_VALID_I(rv), .CURRENT_WINDOW_RESULT_I(win), .LAST_WELD_I(rv & last),
        .SERIAL_FITTED_I(ser), .PROG_OUT_O(po), .INDICATOR_O(ind), .VALVE3_O(v3), .ABORT_O(ab),
        .HOLD_STOP_O(hs), .SEND_O(snd), .SHOW_CURRENT_O(shw), .SEQUENCE_COMPLETE_O(sequence_complete), .ERROR_CODE_O(err));
    wofs_seq_model wofs_seq_model_i (.clk_i(clk), .start_i(start), .bad_i(bad), .abort_i(ab),
        .squeeze_o(sq), .weld_o(wd), .hold_o(hd), .valid_o(rv), .window_o(win));
    // ====================================================
    // Scenarios
    initial forever #4 clk = ~clk;
    task automatic ck(input logic [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic flt(input logic [4:0] c, input logic [8:0] m);
        code = c;
        for (int i = 0; i < 9; i++) begin
            f = 9'h001 << i;
            cyc(5);
            ck({7'h00, po}, {7'h00, |(f & m)});
            if (c == 5'h10)
                ck(err, |(f & m) ? 8'h1A : 8'h00);
        end
        f = 9'h000;
    endtask
    // Valve pulses outlast a run by far; the next code change is what clears them.
    // Outputs are read once a cycle after the edge, so one-cycle pulses count as well as levels.
    // Bits from the top: indicator, show, end of sequence, output, abort, send, valve, hold stop.
    task automatic seq(input logic [4:0] c, input logic b, input logic [7:0] m, e);
        logic [7:0] seen = 8'h00;
        code = c;
        bad = b;
        cyc(6);
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        repeat (30) begin
            cyc(1);
            seen = seen | {ind, shw, sequence_complete, po, ab, snd, v3, hs};
        end
        ck(seen & m, e);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #40000;
        n_mismatch++;
        summarize();
    end
    initial begin
        cyc(3);
        rst = 1'b0;
        cyc(2);
        flt(5'h0B, 9'h010);
        flt(5'h0F, 9'h180);
        flt(5'h10, 9'h060);
        flt(5'h11, 9'h01E);
        flt(5'h12, 9'h001);
        inh = 1'b0;
        seq(5'h13, 1'b0, 8'hFF, 8'h00);
        inh = 1'b1;
        seq(5'h13, 1'b0, 8'hFF, 8'h10);
        seq(5'h14, 1'b0, 8'hFF, 8'h10);
        seq(5'h0D, 1'b1, 8'hFF, 8'h82);
        seq(5'h0E, 1'b1, 8'hFF, 8'h88);
        seq(5'h16, 1'b0, 8'hFF, 8'h04);
        last = 1'b0;
        seq(5'h16, 1'b1, 8'hFF, 8'h04);
        seq(5'h16, 1'b0, 8'hFF, 8'h00);
        last = 1'b1;
        seq(5'h17, 1'b1, 8'hFF, 8'h04);
        ser = 1'b0;
        seq(5'h17, 1'b1, 8'hFF, 8'h00);
        ser = 1'b1;
        seq(5'h17, 1'b0, 8'hFF, 8'h00);
        seq(5'h0C, 1'b1, 8'hFF, 8'h80);
        seq(5'h18, 1'b1, 8'hFF, 8'hC0);
        seq(5'h19, 1'b1, 8'hFF, 8'hE0);
        seq(5'h1A, 1'b1, 8'hFF, 8'h81);
        seq(5'h1B, 1'b1, 8'hFF, 8'h8A);
        inh = 1'b0;
        seq(5'h1C, 1'b0, 8'hFF, 8'h00);
        inh = 1'b1;
        seq(5'h1C, 1'b0, 8'hFF, 8'h22);
        seq(5'h15, 1'b1, 8'hFF, 8'h00);
        seq(5'h1D, 1'b1, 8'hFF, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
